// >>> hw/ddr_link_pkg.sv
// Summary of operation
// R1: Activate carries row; read/write carry column, auto-precharge bit
// R2: Precharge flag low one bank, high all
// R3: Load-mode places op code on address inputs
// R4: Bank select picks bank for commands
// R5: Bank select picks mode register on load-mode
// R6: Inputs sampled on link clock rise
// R7: Clock gate low enters power-down or self refresh
// R8: Self-refresh exit ignores link clock
// R9: Power-down/self refresh disable most receivers
// R10: Chip select high masks every command
// R11: Command from select, row, column, write strobes
// R12: Masked write beats are discarded
// R13: Each byte lane has own mask, strobe
// R14: Termination enable switches termination on
// R15: Termination disabled by mode ignores enable
// R16: Read strobe edge-aligned, write strobe centred
// R17: Complement strobe only in differential mode
// R18: Redundant strobe drives reads only
// R19: Redundant strobe off makes ball a mask
// R20: Redundant complement needs both enables
// R21: Strobe complement disable bit in extended register
// R22: Bursts of four or eight from column
// R23: Controller deselects when idle
// R24: Load-mode only with banks idle
`default_nettype none
package ddr_link_pkg;
	localparam int DQ_W = 16;
	localparam int BA_W = 3;
	localparam int A_W = 14;
	localparam int BANKS = 8;
	localparam int BEATS = 8;
	localparam int CLK_NS = 5;
	localparam int LINK_HALF_NS = 20;
	localparam int CK_HALF = LINK_HALF_NS / CLK_NS;
	localparam int PH_W = 3;
	localparam logic [PH_W-1:0] PH_RISE = 3'h0;
	localparam logic [PH_W-1:0] PH_FALL = PH_W'(CK_HALF);
	localparam logic [PH_W-1:0] PH_MID_HI = PH_W'(CK_HALF / 2);
	localparam logic [PH_W-1:0] PH_MID_LO = PH_W'(CK_HALF + CK_HALF / 2);
	localparam logic [2:0] BL8_CODE = 3'h3;
	localparam logic [3:0] BEATS_BL4 = 4'h4;
	localparam logic [3:0] BEATS_BL8 = 4'h8;
	localparam int MODE_BL_LSB = 0;
	localparam int PRECHARGE_FLAG_ADDR_BIT = 10;
	localparam int STROBE_COMP_DISABLE_BIT = 10;
	localparam int REDUNDANT_STROBE_EN_BIT = 11;
	localparam int TERM_SEL_LO_BIT = 2;
	localparam int TERM_SEL_HI_BIT = 6;
	localparam logic [A_W-1:0] BASE_MODE_RST = 14'h0002;
	localparam logic [A_W-1:0] EXT_MODE_RST = 14'h0000;
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_CMD = 6'h04;
	localparam logic [5:0] OFS_STATUS = 6'h08;
	localparam logic [5:0] OFS_WMASK = 6'h0C;
	localparam logic [1:0] OFS_WDATA_HI = 2'h1;
	localparam logic [1:0] OFS_RDATA_HI = 2'h2;
	localparam int CMD_BANK_LSB = 4;
	localparam int CMD_ADDR_LSB = 16;
	localparam int CTRL_CKE_BIT = 0;
	localparam int CTRL_TERM_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h1;
	typedef enum logic [1:0] {
		SEL_BASE = 2'b00, SEL_EXT = 2'b01, SEL_EXT2 = 2'b10, SEL_EXT3 = 2'b11
	} mode_sel_e;
	typedef enum logic [3:0] {
		CMD_LOAD_MODE = 4'b0000, CMD_REFRESH = 4'b0001, CMD_PRECHARGE = 4'b0010,
		CMD_ACTIVATE = 4'b0011, CMD_WRITE = 4'b0100, CMD_READ = 4'b0101,
		CMD_TERMINATE = 4'b0110, CMD_NOP = 4'b0111, CMD_DESELECT = 4'b1111
	} cmd_e;
	typedef enum logic [1:0] {
		PWR_ON = 2'b00, PWR_PRE_PD = 2'b01, PWR_ACT_PD = 2'b10, PWR_SELF_REF = 2'b11
	} pwr_e;
endpackage
`default_nettype wire

// >>> hw/ddr_link_if.sv
`default_nettype none
interface ddr_link_if;
	import ddr_link_pkg::*;
	logic             ck;
	logic             cs_n;
	logic             ras_n;
	logic             cas_n;
	logic             we_n;
	logic [BA_W-1:0]  ba;
	logic [A_W-1:0]   addr;
	logic             cke;
	logic             termination_enable;
	logic             low_byte_mask;
	logic             high_byte_mask;
	logic [DQ_W-1:0]  dq_c;
	logic             dq_c_oe;
	logic [DQ_W-1:0]  dq_d;
	logic             dq_d_oe;
	logic [DQ_W-1:0]  dq;
	logic [1:0]       strobe_c;
	logic             strobe_c_oe;
	logic [1:0]       strobe_d;
	logic             strobe_d_oe;
	logic [1:0]       strobe_comp_d;
	logic             strobe_comp_oe;
	logic [1:0]       strobe;
	logic             redundant_read_strobe;
	logic             redundant_read_strobe_oe;
	logic             redundant_read_strobe_comp;
	logic             redundant_read_strobe_comp_oe;
	// Bus level: device wins, undriven reads low
	assign dq = dq_d_oe ? dq_d : (dq_c_oe ? dq_c : '0);
	assign strobe = strobe_d_oe ? strobe_d : (strobe_c_oe ? strobe_c : 2'h0);
	modport ctl (
		output ck, cs_n, ras_n, cas_n, we_n, ba, addr, cke, termination_enable,
		output low_byte_mask, high_byte_mask, dq_c, dq_c_oe, strobe_c, strobe_c_oe,
		input  dq, strobe
	);
	modport dev (
		input  ck, cs_n, ras_n, cas_n, we_n, ba, addr, cke, termination_enable,
		input  low_byte_mask, high_byte_mask, dq, strobe,
		output dq_d, dq_d_oe, strobe_d, strobe_d_oe, strobe_comp_d, strobe_comp_oe,
		output redundant_read_strobe, redundant_read_strobe_oe,
		output redundant_read_strobe_comp, redundant_read_strobe_comp_oe
	);
endinterface
`default_nettype wire

// >>> hw/ddr_dev_end.sv
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`default_nettype none
module ddr_dev_end
	import ddr_link_pkg::*;
(
	input  wire logic         sys_clk_i,
	input  wire logic         rst_i,
	ddr_link_if.dev           link,
	output logic              term_on_o,
	output logic [1:0]        power_state_o,
	output logic [BANKS-1:0]  banks_open_o
);
	localparam int SYN_W = 1 + 4 + BA_W + A_W + 2 + DQ_W + 4;
	typedef enum logic [1:0] {
		D_IDLE  = 2'b00,
		D_READ  = 2'b01,
		D_WRITE = 2'b10
	} dev_st_e;

	logic [SYN_W-1:0]  sync1_ff;
	logic [SYN_W-1:0]  sync2_ff;
	logic              ck_prev_ff;
	logic [1:0]        strobe_prev_ff;
	logic [A_W-1:0]    mode_ff [4];
	logic [BANKS-1:0]  open_ff;
	logic [BANKS-1:0]  row_lsb_ff;
	pwr_e              pwr_ff;
	dev_st_e           st_ff;
	logic [BA_W-1:0]   bank_ff;
	logic [2:0]        col_ff;
	logic              row_ff;
	logic              auto_ff;
	logic [3:0]        beat_ff;
	logic [3:0]        wbeat_ff [2];
	logic [DQ_W-1:0]   dq_out_ff;
	logic              strobe_out_ff;
	logic              rd_oe_ff;
	logic              term_ff;
	logic [7:0]        mem_ff [2][128];

	wire logic [SYN_W-1:0] pins_raw;
	wire logic             s_ck;
	wire logic [3:0]       s_cmd_raw;
	wire logic [BA_W-1:0]  s_ba;
	wire logic [A_W-1:0]   s_addr;
	wire logic             s_cke;
	wire logic             s_term;
	wire logic [DQ_W-1:0]  s_dq;
	wire logic [1:0]       s_strobe;
	wire logic [1:0]       s_mask;
	cmd_e                  s_cmd;
	wire logic             ck_rise;
	wire logic             ck_edge;
	wire logic             decode_en;
	wire logic             do_act;
	wire logic             do_pre;
	wire logic             do_rd;
	wire logic             do_wr;
	wire logic             do_mode;
	wire logic             bl8;
	wire logic [3:0]       beats_n;
	wire logic             comp_off;
	wire logic             rds_en;
	wire logic             term_cfg;
	wire logic             burst_end;
	wire logic             wr_done;
	wire logic [6:0]       rd_idx;

	assign pins_raw = {link.ck, link.cs_n, link.ras_n, link.cas_n, link.we_n, link.ba,
		link.addr, link.cke, link.termination_enable, link.dq, link.strobe,
		link.high_byte_mask, link.low_byte_mask};
	assign {s_ck, s_cmd_raw, s_ba, s_addr, s_cke, s_term, s_dq, s_strobe, s_mask} = sync2_ff;

	// R10: select high masks command
	// R11: four-bit command code
	assign s_cmd = s_cmd_raw[3] ? CMD_DESELECT : cmd_e'(s_cmd_raw);
	// R6: act on link clock rise
	assign ck_rise = s_ck & ~ck_prev_ff;
	assign ck_edge = s_ck ^ ck_prev_ff;
	// R9: receivers off outside active power state
	assign decode_en = ck_rise & s_cke & (pwr_ff == PWR_ON);
	assign do_act = decode_en & (s_cmd == CMD_ACTIVATE);
	assign do_pre = decode_en & (s_cmd == CMD_PRECHARGE);
	assign do_rd = decode_en & (s_cmd == CMD_READ) & (st_ff == D_IDLE);
	assign do_wr = decode_en & (s_cmd == CMD_WRITE) & (st_ff == D_IDLE);
	assign do_mode = decode_en & (s_cmd == CMD_LOAD_MODE);

	// R22: burst length from base register
	assign bl8 = mode_ff[SEL_BASE][MODE_BL_LSB +: 3] == BL8_CODE;
	assign beats_n = bl8 ? BEATS_BL8 : BEATS_BL4;
	// R21: complement disable bit
	assign comp_off = mode_ff[SEL_EXT][STROBE_COMP_DISABLE_BIT];
	assign rds_en = mode_ff[SEL_EXT][REDUNDANT_STROBE_EN_BIT];
	assign term_cfg = mode_ff[SEL_EXT][TERM_SEL_LO_BIT] | mode_ff[SEL_EXT][TERM_SEL_HI_BIT];

	assign burst_end = (st_ff == D_READ) & ck_edge & (beat_ff == beats_n);
	assign wr_done = (st_ff == D_WRITE) & (wbeat_ff[0] == beats_n) & (wbeat_ff[1] == beats_n);

	// R22: sequential wrap within burst
	function automatic logic [2:0] col_at(input logic [3:0] beat);
		col_at = bl8 ? col_ff + beat[2:0] : {col_ff[2], col_ff[1:0] + beat[1:0]};
	endfunction

	assign rd_idx = {bank_ff, row_ff, col_at(beat_ff)};

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			ck_prev_ff <= 1'b0;
			strobe_prev_ff <= 2'h0;
		end else begin
			sync1_ff <= pins_raw;
			sync2_ff <= sync1_ff;
			ck_prev_ff <= s_ck;
			strobe_prev_ff <= s_strobe;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_ff[0] <= BASE_MODE_RST;
			mode_ff[1] <= EXT_MODE_RST;
			mode_ff[2] <= EXT_MODE_RST;
			mode_ff[3] <= EXT_MODE_RST;
		end else if (do_mode) begin
			// R3: op code from address
			// R5: register chosen by bank select
			mode_ff[s_ba[1:0]] <= s_addr;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			open_ff <= '0;
			row_lsb_ff <= '0;
		end else if (do_act) begin
			// R1: row taken on activate
			// R4: bank select names bank
			open_ff[s_ba] <= 1'b1;
			row_lsb_ff[s_ba] <= s_addr[0];
		end else if (do_pre) begin
			// R2: one bank or all
			if (s_addr[PRECHARGE_FLAG_ADDR_BIT]) begin
				open_ff <= '0;
			end else begin
				open_ff[s_ba] <= 1'b0;
			end
		end else if ((burst_end | wr_done) & auto_ff) begin
			open_ff[bank_ff] <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pwr_ff <= PWR_ON;
		end else begin
			case (pwr_ff)
				PWR_ON: begin
					// R7: clock gate low picks state
					if (ck_rise & ~s_cke) begin
						if ((s_cmd == CMD_REFRESH) & ~|open_ff) begin
							pwr_ff <= PWR_SELF_REF;
						end else if (~|open_ff) begin
							pwr_ff <= PWR_PRE_PD;
						end else begin
							pwr_ff <= PWR_ACT_PD;
						end
					end
				end
				PWR_PRE_PD, PWR_ACT_PD: begin
					if (ck_rise & s_cke) begin
						pwr_ff <= PWR_ON;
					end
				end
				PWR_SELF_REF: begin
					// R8: exit without link clock edge
					if (s_cke) begin
						pwr_ff <= PWR_ON;
					end
				end
				default: pwr_ff <= PWR_ON;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			term_ff <= 1'b0;
		end else if (pwr_ff == PWR_SELF_REF) begin
			term_ff <= 1'b0;
		end else if (ck_rise) begin
			// R14: registered termination enable
			// R15: ignored when mode disables it
			term_ff <= s_term & term_cfg;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_ff <= D_IDLE;
			bank_ff <= '0;
			col_ff <= 3'h0;
			row_ff <= 1'b0;
			auto_ff <= 1'b0;
		end else if (do_rd | do_wr) begin
			// R1: column and auto precharge
			st_ff <= do_rd ? D_READ : D_WRITE;
			bank_ff <= s_ba;
			col_ff <= s_addr[2:0];
			row_ff <= row_lsb_ff[s_ba];
			auto_ff <= s_addr[PRECHARGE_FLAG_ADDR_BIT];
		end else if (burst_end | wr_done) begin
			st_ff <= D_IDLE;
		end
	end

	// R16: strobe toggles with each read beat
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			beat_ff <= 4'h0;
			dq_out_ff <= '0;
			strobe_out_ff <= 1'b0;
			rd_oe_ff <= 1'b0;
		end else if (do_rd) begin
			beat_ff <= 4'h0;
			strobe_out_ff <= 1'b0;
			rd_oe_ff <= 1'b1;
		end else if (burst_end) begin
			rd_oe_ff <= 1'b0;
		end else if ((st_ff == D_READ) & ck_edge) begin
			dq_out_ff <= {mem_ff[1][rd_idx], mem_ff[0][rd_idx]};
			strobe_out_ff <= ~strobe_out_ff;
			beat_ff <= beat_ff + 4'h1;
		end
	end

	// R13: one lane per byte with own strobe and mask
	for (genvar g = 0; g < 2; g++) begin : g_lane
		wire logic       s_edge;
		wire logic       lane_mask;
		wire logic [6:0] w_idx;
		assign s_edge = s_strobe[g] ^ strobe_prev_ff[g];
		// R18: redundant strobe ignored in writes
		// R19: ball is a mask when strobe off
		assign lane_mask = (g == 0) ? (~rds_en & s_mask[0]) : s_mask[1];
		assign w_idx = {bank_ff, row_ff, col_at(wbeat_ff[g])};
		always_ff @(posedge sys_clk_i or posedge rst_i) begin
			if (rst_i) begin
				wbeat_ff[g] <= 4'h0;
			end else if (do_wr) begin
				wbeat_ff[g] <= 4'h0;
			end else if ((st_ff == D_WRITE) & s_edge & (wbeat_ff[g] != beats_n)) begin
				wbeat_ff[g] <= wbeat_ff[g] + 4'h1;
			end
		end
		// R12: masked beat is dropped
		always_ff @(posedge sys_clk_i) begin
			if ((st_ff == D_WRITE) & s_edge & (wbeat_ff[g] != beats_n) & ~lane_mask) begin
				mem_ff[g][w_idx] <= s_dq[g*8 +: 8];
			end
		end
	end

	assign link.dq_d = dq_out_ff;
	assign link.dq_d_oe = rd_oe_ff;
	assign link.strobe_d = {2{strobe_out_ff}};
	assign link.strobe_d_oe = rd_oe_ff;
	assign link.strobe_comp_d = {2{~strobe_out_ff}};
	// R17: complement only in differential mode
	assign link.strobe_comp_oe = rd_oe_ff & ~comp_off;
	assign link.redundant_read_strobe = strobe_out_ff;
	assign link.redundant_read_strobe_oe = rd_oe_ff & rds_en;
	assign link.redundant_read_strobe_comp = ~strobe_out_ff;
	// R20: both enables needed
	assign link.redundant_read_strobe_comp_oe = rd_oe_ff & rds_en & ~comp_off;
	assign term_on_o = term_ff;
	assign power_state_o = pwr_ff;
	assign banks_open_o = open_ff;
endmodule
`default_nettype wire

// >>> hw/ddr_ctl_end.sv
`default_nettype none
module ddr_ctl_end
	import ddr_link_pkg::*;
(
	input  wire logic         sys_clk_i,
	input  wire logic         rst_i,
	input  wire logic [5:0]   avs_address_i,
	input  wire logic         avs_read_i,
	input  wire logic         avs_write_i,
	input  wire logic [31:0]  avs_writedata_i,
	output logic [31:0]       avs_readdata_o,
	output logic              avs_waitrequest_o,
	ddr_link_if.ctl           link
);
	typedef enum logic [2:0] {
		C_IDLE = 3'b000, C_WAIT = 3'b001, C_HOLD = 3'b010, C_WR = 3'b011, C_RD = 3'b100
	} ctl_e;

	logic [1:0]       ctrl_ff;
	logic [15:0]      wmask_ff;
	logic [DQ_W-1:0]  wdata_ff [BEATS];
	logic [DQ_W-1:0]  rdata_ff [BEATS];
	logic             busy_ff;
	logic             rvalid_ff;
	logic             ack_ff;
	logic [31:0]      readdata_ff;
	cmd_e             cmd_ff;
	logic [BA_W-1:0]  bank_ff;
	logic [A_W-1:0]   addr_ff;
	cmd_e             pin_cmd_ff;
	logic [BA_W-1:0]  pin_ba_ff;
	logic [A_W-1:0]   pin_addr_ff;
	ctl_e             st_ff;
	logic [PH_W-1:0]  ph_ff;
	logic             ck_ff;
	logic             bl8_ff;
	logic [3:0]       beat_ff;
	logic [DQ_W-1:0]  dq_ff;
	logic [1:0]       mask_ff;
	logic             strobe_ff;
	logic             wr_oe_ff;
	logic [17:0]      sync1_ff;
	logic [17:0]      sync2_ff;
	logic             strobe_prev_ff;

	wire logic             req;
	wire logic             sel_cmd;
	wire logic             sel_wdata;
	wire logic             sel_rdata;
	wire logic             stall;
	wire logic             take;
	wire logic             wr_go;
	wire logic [31:0]      rd_mux;
	wire logic [PH_W-1:0]  ph_nxt;
	wire logic [3:0]       beats_n;
	wire logic             at_edge;
	wire logic             at_mid;
	wire logic             rd_edge;
	wire logic [2:0]       wi;

	assign req = avs_read_i | avs_write_i;
	assign sel_cmd = avs_address_i == OFS_CMD;
	assign sel_wdata = avs_address_i[5:4] == OFS_WDATA_HI;
	assign sel_rdata = avs_address_i[5:4] == OFS_RDATA_HI;
	assign wi = {avs_address_i[3:2], 1'b0};
	// New command waits while link is busy
	assign stall = avs_write_i & sel_cmd & busy_ff;
	assign take = req & ~ack_ff & ~stall;
	assign wr_go = avs_write_i & ack_ff;
	assign avs_waitrequest_o = req & ~ack_ff;
	assign avs_readdata_o = readdata_ff;
	assign rd_mux = (avs_address_i == OFS_CTRL) ? {30'h0, ctrl_ff} :
		(avs_address_i == OFS_STATUS) ? {30'h0, rvalid_ff, busy_ff} :
		(avs_address_i == OFS_WMASK) ? {16'h0, wmask_ff} :
		sel_wdata ? {wdata_ff[wi + 3'h1], wdata_ff[wi]} :
		sel_rdata ? {rdata_ff[wi + 3'h1], rdata_ff[wi]} : 32'h0;

	assign ph_nxt = ph_ff + 3'h1;
	assign beats_n = bl8_ff ? BEATS_BL8 : BEATS_BL4;
	assign at_edge = (ph_nxt == PH_RISE) | (ph_nxt == PH_FALL);
	assign at_mid = (ph_nxt == PH_MID_HI) | (ph_nxt == PH_MID_LO);
	assign rd_edge = (st_ff == C_RD) & (sync2_ff[16] ^ strobe_prev_ff);

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			readdata_ff <= 32'h0;
			ctrl_ff <= CTRL_RST;
			wmask_ff <= 16'h0;
		end else begin
			ack_ff <= take;
			if (take) begin
				readdata_ff <= rd_mux;
			end
			if (wr_go & (avs_address_i == OFS_CTRL)) begin
				ctrl_ff <= avs_writedata_i[1:0];
			end
			if (wr_go & (avs_address_i == OFS_WMASK)) begin
				wmask_ff <= avs_writedata_i[15:0];
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (wr_go & sel_wdata) begin
			wdata_ff[wi] <= avs_writedata_i[15:0];
			wdata_ff[wi + 3'h1] <= avs_writedata_i[31:16];
		end
		if (rd_edge) begin
			rdata_ff[beat_ff[2:0]] <= sync2_ff[15:0];
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ph_ff <= '0;
			ck_ff <= 1'b1;
			sync1_ff <= '0;
			sync2_ff <= '0;
			strobe_prev_ff <= 1'b0;
		end else begin
			ph_ff <= ph_nxt;
			ck_ff <= ph_nxt < PH_FALL;
			sync1_ff <= {link.strobe, link.dq};
			sync2_ff <= sync1_ff;
			strobe_prev_ff <= sync2_ff[16];
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_cmd_ff <= CMD_DESELECT;
			pin_ba_ff <= '0;
			pin_addr_ff <= '0;
		end else if (ph_nxt == PH_FALL) begin
			// R23: deselect outside command slot
			pin_cmd_ff <= (st_ff == C_WAIT) ? cmd_ff : CMD_DESELECT;
			pin_ba_ff <= bank_ff;
			pin_addr_ff <= addr_ff;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_ff <= C_IDLE;
			busy_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			cmd_ff <= CMD_NOP;
			bank_ff <= '0;
			addr_ff <= '0;
			bl8_ff <= 1'b0;
			beat_ff <= 4'h0;
			dq_ff <= '0;
			mask_ff <= 2'h0;
			strobe_ff <= 1'b0;
			wr_oe_ff <= 1'b0;
		end else begin
			case (st_ff)
				C_IDLE: begin
					if (wr_go & sel_cmd) begin
						cmd_ff <= cmd_e'({1'b0, avs_writedata_i[2:0]});
						bank_ff <= avs_writedata_i[CMD_BANK_LSB +: BA_W];
						addr_ff <= avs_writedata_i[CMD_ADDR_LSB +: A_W];
						busy_ff <= 1'b1;
						st_ff <= C_WAIT;
					end
				end
				C_WAIT: begin
					if (ph_nxt == PH_FALL) begin
						st_ff <= C_HOLD;
					end
				end
				C_HOLD: begin
					if (ph_nxt == PH_RISE) begin
						beat_ff <= 4'h0;
						// R3: snoop burst length of base register load
						// R24: software keeps banks idle here
						if ((cmd_ff == CMD_LOAD_MODE) & (bank_ff[1:0] == SEL_BASE)) begin
							bl8_ff <= addr_ff[MODE_BL_LSB +: 3] == BL8_CODE;
						end
						if (cmd_ff == CMD_WRITE) begin
							st_ff <= C_WR;
							wr_oe_ff <= 1'b1;
							strobe_ff <= 1'b0;
							dq_ff <= wdata_ff[0];
							mask_ff <= wmask_ff[1:0];
						end else if (cmd_ff == CMD_READ) begin
							st_ff <= C_RD;
							rvalid_ff <= 1'b0;
						end else begin
							st_ff <= C_IDLE;
							busy_ff <= 1'b0;
						end
					end
				end
				C_WR: begin
					// R16: strobe centred in each beat
					if (at_mid & (beat_ff != beats_n)) begin
						strobe_ff <= ~strobe_ff;
						beat_ff <= beat_ff + 4'h1;
					end else if (at_edge & (beat_ff == beats_n)) begin
						wr_oe_ff <= 1'b0;
						st_ff <= C_IDLE;
						busy_ff <= 1'b0;
					end else if (at_edge) begin
						dq_ff <= wdata_ff[beat_ff[2:0]];
						// R12: mask beat per byte
						mask_ff <= wmask_ff[{beat_ff[2:0], 1'b0} +: 2];
					end
				end
				C_RD: begin
					if (rd_edge) begin
						beat_ff <= beat_ff + 4'h1;
						if (beat_ff == beats_n - 4'h1) begin
							st_ff <= C_IDLE;
							busy_ff <= 1'b0;
							rvalid_ff <= 1'b1;
						end
					end
				end
				default: st_ff <= C_IDLE;
			endcase
		end
	end

	// R6: pins change at fall, stable at rise
	// R11: command code on four strobes
	assign link.ck = ck_ff;
	assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = pin_cmd_ff;
	assign link.ba = pin_ba_ff;
	assign link.addr = pin_addr_ff;
	// R7: clock gate level from register
	assign link.cke = ctrl_ff[CTRL_CKE_BIT];
	assign link.termination_enable = ctrl_ff[CTRL_TERM_BIT];
	assign link.dq_c = dq_ff;
	assign link.dq_c_oe = wr_oe_ff;
	assign link.strobe_c = {2{strobe_ff}};
	assign link.strobe_c_oe = wr_oe_ff;
	assign link.low_byte_mask = mask_ff[0] & wr_oe_ff;
	assign link.high_byte_mask = mask_ff[1] & wr_oe_ff;
endmodule
`default_nettype wire

// >>> sim/ddr_link_assertions.sv
`default_nettype none
module ddr_link_assertions
	import ddr_link_pkg::*;
(
	input wire logic            sys_clk_i,
	input wire logic            rst_i,
	input wire logic            ck,
	input wire logic            cs_n,
	input wire logic            ras_n,
	input wire logic            cas_n,
	input wire logic            we_n,
	input wire logic [BA_W-1:0] ba,
	input wire logic [A_W-1:0]  addr,
	input wire logic [DQ_W-1:0] dq_c,
	input wire logic            dq_c_oe,
	input wire logic            dq_d_oe,
	input wire logic [1:0]      strobe_c,
	input wire logic            strobe_d_oe,
	input wire logic            strobe_comp_oe,
	input wire logic            redundant_read_strobe_oe,
	input wire logic            redundant_read_strobe_comp_oe
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	sequence ck_hi_s; ck[*4]; endsequence
	sequence ck_lo_s; !ck[*4]; endsequence
	sequence pins_hold_s; $stable({cs_n, ras_n, cas_n, we_n, ba, addr})[*3]; endsequence
	link_period_a: assert property (
		$rose(ck) |-> ck_hi_s ##1 ck_lo_s ##1 ck) else $error("link clock period off");
	cmd_stable_a: assert property (
		$rose(ck) |-> ##1 pins_hold_s) else $error("command pins move near rise");
	cmd_hold_a: assert property (
		$fell(cs_n) |-> !cs_n[*8]) else $error("command held too short");
	dq_single_a: assert property (
		!(dq_c_oe && dq_d_oe)) else $error("both ends drive data");
	comp_needs_a: assert property (
		strobe_comp_oe |-> strobe_d_oe) else $error("complement without strobe");
	rcomp_needs_a: assert property (
		redundant_read_strobe_comp_oe |-> redundant_read_strobe_oe && strobe_comp_oe)
		else $error("redundant complement without both enables");
	rstrobe_read_a: assert property (
		redundant_read_strobe_oe |-> strobe_d_oe && !dq_c_oe)
		else $error("redundant strobe outside read");
	wstrobe_mid_a: assert property (
		dq_c_oe && $changed(dq_c) |-> ##2 $changed(strobe_c)) else $error("write strobe not centred");
endmodule
`default_nettype wire

// >>> sim/tb.sv
`default_nettype none
module tb
	import ddr_link_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic             sys_clk_i = 1'b0;
	logic             rst_i = 1'b1;
	logic [5:0]       adr = '0;
	logic             rd_req = 1'b0;
	logic             wr_req = 1'b0;
	logic [31:0]      wdata = '0;
	logic [31:0]      rdata;
	logic [31:0]      rq;
	logic             waitreq;
	logic             term_on;
	logic [1:0]       pwr_state;
	logic [BANKS-1:0] banks_open;
	int               error_cnt = 0;
	int               n_compared = 0;
	ddr_link_if u_ddr_link_if ();
	ddr_ctl_end u_ddr_ctl_end (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(adr),
		.avs_read_i(rd_req), .avs_write_i(wr_req), .avs_writedata_i(wdata),
		.avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .link(u_ddr_link_if));
	ddr_dev_end u_ddr_dev_end (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(u_ddr_link_if),
		.term_on_o(term_on), .power_state_o(pwr_state), .banks_open_o(banks_open));
	ddr_link_assertions u_ddr_link_assertions (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.ck(u_ddr_link_if.ck), .cs_n(u_ddr_link_if.cs_n), .ras_n(u_ddr_link_if.ras_n),
		.cas_n(u_ddr_link_if.cas_n), .we_n(u_ddr_link_if.we_n), .ba(u_ddr_link_if.ba),
		.addr(u_ddr_link_if.addr), .dq_c(u_ddr_link_if.dq_c), .dq_c_oe(u_ddr_link_if.dq_c_oe),
		.dq_d_oe(u_ddr_link_if.dq_d_oe), .strobe_c(u_ddr_link_if.strobe_c),
		.strobe_d_oe(u_ddr_link_if.strobe_d_oe), .strobe_comp_oe(u_ddr_link_if.strobe_comp_oe),
		.redundant_read_strobe_oe(u_ddr_link_if.redundant_read_strobe_oe),
		.redundant_read_strobe_comp_oe(u_ddr_link_if.redundant_read_strobe_comp_oe));
	always #2.5 sys_clk_i = ~sys_clk_i;
	task automatic complete_run();
		$display("compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		adr <= a;
		wr_req <= w;
		rd_req <= !w;
		wdata <= d;
		do @(posedge sys_clk_i); while (waitreq !== 1'b0);
		rq = rdata;
		wr_req <= 1'b0;
		rd_req <= 1'b0;
	endtask
	task automatic cmd(input cmd_e c, input logic [2:0] b, input logic [13:0] a);
		bus(1'b1, OFS_CMD, {2'b00, a, 9'h000, b, 1'b0, c[2:0]});
		for (int i = 0; i < 100; i++) begin
			bus(1'b0, OFS_STATUS, '0);
			if (rq[0] === 1'b0) break;
		end
		// Device acts about three clocks after the rise that ends busy
		repeat (4) @(posedge sys_clk_i);
	endtask
	task automatic settle();
		repeat (40) @(posedge sys_clk_i);
	endtask
	function automatic logic [31:0] pat(input int k);
		return 32'h1357_9BDF + 32'(k) * 32'h0101_0101;
	endfunction
	task automatic reset_test();
		bus(1'b0, OFS_CTRL, '0);
		chk(rq, 32'(CTRL_RST));
		bus(1'b0, 6'h3C, '0);
		chk(rq, 32'h0000_0000);
		chk({term_on, pwr_state, banks_open}, 32'h0000_0000);
		chk(32'(u_ddr_link_if.cs_n), 32'h0000_0001);
	endtask
	task automatic data_test(input logic [2:0] b, input int nb, input logic ap);
		logic [31:0] mm;
		logic [15:0] wm = 16'h0096;
		cmd(CMD_ACTIVATE, b, 14'h0001);
		chk(32'(banks_open[b]), 32'h0000_0001);
		bus(1'b1, OFS_WMASK, '0);
		for (int k = 0; k < nb / 2; k++) bus(1'b1, 6'h10 + 6'(4 * k), pat(k));
		cmd(CMD_WRITE, b, 14'h0000);
		bus(1'b1, OFS_WMASK, 32'h0000_0096);
		for (int k = 0; k < nb / 2; k++) bus(1'b1, 6'h10 + 6'(4 * k), ~pat(k));
		cmd(CMD_WRITE, b, 14'h0000);
		cmd(CMD_READ, b, ap ? 14'h0400 : 14'h0000);
		for (int k = 0; k < nb / 2; k++) begin
			for (int j = 0; j < 4; j++) mm[8 * j +: 8] = {8{wm[4 * k + j]}};
			bus(1'b0, 6'h20 + 6'(4 * k), '0);
			chk(rq, (pat(k) & mm) | (~pat(k) & ~mm));
		end
		chk(32'(banks_open[b]), 32'(!ap));
	endtask
	task automatic precharge_test();
		cmd(CMD_ACTIVATE, 3'h1, 14'h0002);
		cmd(CMD_PRECHARGE, 3'h6, 14'h0000);
		chk(32'(banks_open), 32'h0000_0002);
		cmd(CMD_PRECHARGE, 3'h0, 14'h0400);
		chk(32'(banks_open), 32'h0000_0000);
	endtask
	task automatic power_test();
		bus(1'b1, OFS_CTRL, 32'h0000_0000);
		settle();
		chk(32'(pwr_state), 32'(PWR_PRE_PD));
		bus(1'b1, OFS_CTRL, 32'h0000_0001);
		settle();
		chk(32'(pwr_state), 32'(PWR_ON));
		cmd(CMD_ACTIVATE, 3'h2, 14'h0003);
		bus(1'b1, OFS_CTRL, 32'h0000_0000);
		settle();
		chk(32'(pwr_state), 32'(PWR_ACT_PD));
		bus(1'b1, OFS_CTRL, 32'h0000_0001);
		settle();
		cmd(CMD_PRECHARGE, 3'h0, 14'h0400);
		// Refresh reaches the pins after the gate drops, before the next rise
		@(negedge u_ddr_link_if.ck);
		bus(1'b1, OFS_CMD, 32'(CMD_REFRESH));
		bus(1'b1, OFS_CTRL, 32'h0000_0000);
		settle();
		chk(32'(pwr_state), 32'(PWR_SELF_REF));
		bus(1'b1, OFS_CTRL, 32'h0000_0001);
		repeat (4) @(posedge sys_clk_i);
		chk(32'(pwr_state), 32'(PWR_ON));
	endtask
	task automatic term_test();
		cmd(CMD_LOAD_MODE, 3'(SEL_EXT), 14'h0804);
		bus(1'b1, OFS_CTRL, 32'h0000_0003);
		settle();
		chk(32'(term_on), 32'h0000_0001);
		cmd(CMD_READ, 3'h3, 14'h0000);
		cmd(CMD_LOAD_MODE, 3'(SEL_EXT), 14'h0000);
		settle();
		chk(32'(term_on), 32'h0000_0000);
		bus(1'b1, OFS_CTRL, 32'h0000_0001);
	endtask
	initial begin
		repeat (16) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		reset_test();
		data_test(3'h3, 4, 1'b1);
		cmd(CMD_LOAD_MODE, 3'(SEL_BASE), 14'(BL8_CODE));
		data_test(3'h6, 8, 1'b0);
		precharge_test();
		power_test();
		term_test();
		complete_run();
	end
	initial begin
		#150_000;
		error_cnt++;
		complete_run();
	end
endmodule
`default_nettype wire
